// ===== rtl/odc_dac_end.sv
// Serial control end of an eight-channel DAC: shift register, decode,
// input and DAC code registers, power-down flags and chained output.
// Assumes link pins are asynchronous to clk and slower than clk / 6.
//
// What this block does
// - Shift data only while select is low
// - Select rising edge ends transfer, runs command
// - Data bit captured on serial clock rise
// - Accept both 24-bit and 32-bit words
// - Serial out is input delayed 32 edges
// - Serial out always driven, never floating
// - Clear pin zeroes input and DAC registers
// - Reset starts every channel at zero code
// - Code 0000 writes addressed input register only
// - Code 0001 updates, powers up addressed channel
// - Code 0010 writes addressed input register, updates all channels
// - Code 0011 writes and updates addressed channel
// - Host sends only defined command, address codes
// - Layout: command, address, data, MSB first
// - Long form: eight pad bits, last 24 used
// - Code 0100 powers down, contents kept
// - Code 1111 leaves codes and power flags alone
`timescale 1ns/10ps
module odc_dac_end
   import odc_pkg::*;
#(
   parameter int DATA_W = ODC_DATA_W_DEF
) (
   input wire logic clk,
   input wire logic rst,
   odc_link_if.device link,
   output logic [ODC_CHANNELS*DATA_W-1:0] dac_code_flat,
   output logic [ODC_CHANNELS-1:0] powered_down,
   output logic exec_pulse,
   output logic [3:0] last_cmd
);

   // Synchroniser stages for the link pins
   logic sck_s1_reg;
   logic sck_s2_reg;
   logic sck_prev_reg;
   logic sdi_s1_reg;
   logic sdi_s2_reg;
   logic sel_s1_reg;
   logic sel_s2_reg;
   logic sel_prev_reg;

   // Shift register and serial output
   logic [ODC_WORD_LONG-1:0] shift_reg;
   logic sdo_reg;

   // Channel storage
   logic [DATA_W-1:0] in_code_reg [ODC_CHANNELS];
   logic [DATA_W-1:0] dac_code_reg [ODC_CHANNELS];
   logic [ODC_CHANNELS-1:0] pd_reg;
   logic exec_reg;
   logic [3:0] last_cmd_reg;

   // Decoded view of the word
   logic sck_rise;
   logic sck_fall;
   logic load_edge;
   logic clr_any;
   logic [3:0] cmd;
   logic [ODC_CHANNELS-1:0] sel;
   logic [DATA_W-1:0] code;

   // Clear pin acts as an extra asynchronous reset of the code registers;
   // it bypasses the synchronisers on purpose so it works with no clock
   assign clr_any = rst | ~link.async_zero_n;

   // Two flip-flops on the clock, data and select link pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sdi_s1_reg <= 1'b0;
         sdi_s2_reg <= 1'b0;
         sel_s1_reg <= 1'b1;
         sel_s2_reg <= 1'b1;
      end else begin
         sck_s1_reg <= link.sck;
         sck_s2_reg <= sck_s1_reg;
         sdi_s1_reg <= link.sdi;
         sdi_s2_reg <= sdi_s1_reg;
         sel_s1_reg <= link.select_load_n;
         sel_s2_reg <= sel_s1_reg;
      end
   end

   // Previous values for edge finding, taken from the second stage only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_prev_reg <= 1'b0;
         sel_prev_reg <= 1'b1;
      end else begin
         sck_prev_reg <= sck_s2_reg;
         sel_prev_reg <= sel_s2_reg;
      end
   end

   // Rising clock edges count only while select is low; falling edges always count
   assign sck_rise = sck_s2_reg & ~sck_prev_reg & ~sel_s2_reg;
   assign sck_fall = ~sck_s2_reg & sck_prev_reg;
   assign load_edge = sel_s2_reg & ~sel_prev_reg;

   // Decode always from the last 24 bits shifted in, so pad bits of a
   // long word simply fall off the top
   assign cmd = shift_reg[ODC_CMD_MSB:ODC_CMD_LSB];
   assign sel = odc_chan_mask(shift_reg[ODC_ADDR_MSB:ODC_ADDR_LSB]);
   assign code = shift_reg[ODC_DATA_MSB -: DATA_W];

   // Input shift register, MSB enters first and moves up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_reg <= '0;
      end else if (sck_rise) begin
         shift_reg <= {shift_reg[ODC_WORD_LONG-2:0], sdi_s2_reg};
      end
   end

   // Chained output: top bit after the rise moves out on the next fall,
   // and keeps driving between frames
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_reg <= 1'b0;
      end else if (sck_fall) begin
         sdo_reg <= shift_reg[ODC_WORD_LONG-1];
      end
   end
   assign link.sdo = sdo_reg;

   // Input registers
   always_ff @(posedge clk or posedge clr_any) begin
      if (clr_any) begin
         for (int i = 0; i < ODC_CHANNELS; i++) begin
            in_code_reg[i] <= DATA_W'(ODC_CODE_RESET);
         end
      end else if (load_edge) begin
         for (int i = 0; i < ODC_CHANNELS; i++) begin
            case (cmd)
               ODC_CMD_WRITE,
               ODC_CMD_WRITE_UPD_ALL,
               ODC_CMD_WRITE_UPD: begin
                  if (sel[i]) begin
                     in_code_reg[i] <= code;
                  end
               end
               default: begin
                  // Update, power-down, no-op and reserved keep contents
                  in_code_reg[i] <= in_code_reg[i];
               end
            endcase
         end
      end
   end

   // DAC registers; write-and-update takes the new code directly
   always_ff @(posedge clk or posedge clr_any) begin
      if (clr_any) begin
         for (int i = 0; i < ODC_CHANNELS; i++) begin
            dac_code_reg[i] <= DATA_W'(ODC_CODE_RESET);
         end
      end else if (load_edge) begin
         for (int i = 0; i < ODC_CHANNELS; i++) begin
            case (cmd)
               ODC_CMD_UPDATE: begin
                  if (sel[i]) begin
                     dac_code_reg[i] <= in_code_reg[i];
                  end
               end
               ODC_CMD_WRITE_UPD_ALL: begin
                  dac_code_reg[i] <= sel[i] ? code : in_code_reg[i];
               end
               ODC_CMD_WRITE_UPD: begin
                  if (sel[i]) begin
                     dac_code_reg[i] <= code;
                  end
               end
               default: begin
                  dac_code_reg[i] <= dac_code_reg[i];
               end
            endcase
         end
      end
   end

   // Power-down flags; reset and the update commands clear them, the clear pin leaves the
   // power state alone since it only concerns the codes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pd_reg <= '0;
      end else if (load_edge) begin
         case (cmd)
            ODC_CMD_UPDATE,
            ODC_CMD_WRITE_UPD: begin
               pd_reg <= pd_reg & ~sel;
            end
            ODC_CMD_WRITE_UPD_ALL: begin
               pd_reg <= '0;
            end
            ODC_CMD_POWER_DOWN: begin
               pd_reg <= pd_reg | sel;
            end
            default: begin
               pd_reg <= pd_reg;
            end
         endcase
      end
   end

   // Execution marker and command seen, for the user side
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         exec_reg <= 1'b0;
         last_cmd_reg <= ODC_CMD_NOP;
      end else begin
         exec_reg <= load_edge;
         if (load_edge) begin
            last_cmd_reg <= cmd;
         end
      end
   end

   // Flatten channel codes, channel A in the low slice
   always_comb begin
      for (int i = 0; i < ODC_CHANNELS; i++) begin
         dac_code_flat[i*DATA_W +: DATA_W] = dac_code_reg[i];
      end
   end

   assign powered_down = pd_reg;
   assign exec_pulse = exec_reg;
   assign last_cmd = last_cmd_reg;

endmodule : odc_dac_end

// ===== common/odc_pkg.sv
// Constants, field layout and decode helpers for the octal DAC serial link.
// Assumes both link ends and the bench import it whole.
package odc_pkg;

   // Clock rates of the control logic and of the host-made serial clock
   localparam int ODC_CLK_PERIOD_NS = 100;
   localparam int ODC_SCK_PERIOD_NS = 800;
   localparam int ODC_SCK_HALF_DEF = ODC_SCK_PERIOD_NS / (2 * ODC_CLK_PERIOD_NS);

   // Word lengths and layout, MSB first on the wire
   localparam int ODC_WORD_LONG = 32;
   localparam int ODC_WORD_SHORT = 24;
   localparam int ODC_PAD_BITS = 8;
   localparam int ODC_CMD_MSB = 23;
   localparam int ODC_CMD_LSB = 20;
   localparam int ODC_ADDR_MSB = 19;
   localparam int ODC_ADDR_LSB = 16;
   localparam int ODC_DATA_MSB = 15;
   localparam int ODC_DATA_W_DEF = 16;
   localparam int ODC_CHANNELS = 8;
   localparam int ODC_CODE_RESET = 0;

   // Command codes
   localparam logic [3:0] ODC_CMD_WRITE = 4'h0;
   localparam logic [3:0] ODC_CMD_UPDATE = 4'h1;
   localparam logic [3:0] ODC_CMD_WRITE_UPD_ALL = 4'h2;
   localparam logic [3:0] ODC_CMD_WRITE_UPD = 4'h3;
   localparam logic [3:0] ODC_CMD_POWER_DOWN = 4'h4;
   localparam logic [3:0] ODC_CMD_NOP = 4'hf;

   // Channel address codes
   localparam logic [3:0] ODC_ADDR_LAST_CH = 4'h7;
   localparam logic [3:0] ODC_ADDR_ALL = 4'hf;

   // Channel select mask from an address code; reserved codes hit nothing
   function automatic logic [7:0] odc_chan_mask(input logic [3:0] addr);
      logic [7:0] m;
      m = 8'h00;
      if (addr <= ODC_ADDR_LAST_CH) begin
         m[addr[2:0]] = 1'b1;
      end else if (addr == ODC_ADDR_ALL) begin
         m = 8'hff;
      end
      return m;
   endfunction : odc_chan_mask

   // True when command and address of a 24-bit word are both defined
   function automatic logic odc_word_legal(input logic [23:0] w);
      logic [3:0] c;
      c = w[ODC_CMD_MSB:ODC_CMD_LSB];
      return (c <= ODC_CMD_POWER_DOWN || c == ODC_CMD_NOP) &&
             (odc_chan_mask(w[ODC_ADDR_MSB:ODC_ADDR_LSB]) != 8'h00);
   endfunction : odc_word_legal

endpackage : odc_pkg

// ===== common/odc_link_if.sv
// Serial link between the host controller and the octal DAC control end.
// Assumes the bench joins both ends through this; all pins are one-way.
`timescale 1ns/10ps
interface odc_link_if;
   logic select_load_n;
   logic sck;
   logic sdi;
   logic sdo;
   logic async_zero_n;

   // Device end: takes select, clock, data and clear, drives serial out
   modport device (
      input select_load_n,
      input sck,
      input sdi,
      input async_zero_n,
      output sdo
   );

   // Host end: the opposite directions
   modport host (
      output select_load_n,
      output sck,
      output sdi,
      output async_zero_n,
      input sdo
   );
endinterface : odc_link_if

// ===== rtl/odc_host_end.sv
// Host end of the octal DAC link: sends one 24- or 32-bit word per start,
// makes the serial clock by dividing clk, and collects the chained output.
// Assumes the device end samples the link with at least two clk stages.
`timescale 1ns/10ps
module odc_host_end
   import odc_pkg::*;
#(
   parameter int SCK_HALF = ODC_SCK_HALF_DEF
) (
   input wire logic clk,
   input wire logic rst,
   odc_link_if.host link,
   input wire logic start,
   input wire logic [ODC_WORD_LONG-1:0] tx_word,
   input wire logic long_word,
   input wire logic clear_req,
   output logic busy,
   output logic done,
   output logic refused,
   output logic [ODC_WORD_LONG-1:0] rx_word
);

   typedef enum logic [4:0] {
      ODC_H_IDLE = 5'h01,
      ODC_H_LOW = 5'h02,
      ODC_H_HIGH = 5'h04,
      ODC_H_TAIL = 5'h08,
      ODC_H_GAP = 5'h10
   } odc_host_state_type;

   odc_host_state_type state_reg;
   logic [7:0] cnt_reg;
   logic [5:0] bits_reg;
   logic [ODC_WORD_LONG-1:0] tx_reg;
   logic [ODC_WORD_LONG-1:0] rx_reg;
   logic sel_n_reg;
   logic sck_reg;
   logic sdi_reg;
   logic zero_n_reg;
   logic done_reg;
   logic refused_reg;
   logic sdo_s1_reg;
   logic sdo_s2_reg;
   logic half_end;

   assign half_end = (cnt_reg == 8'(SCK_HALF - 1));

   // Returning chained data passes two stages before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         sdo_s1_reg <= link.sdo;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   // Clear line follows the user request, registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_n_reg <= 1'b1;
      end else begin
         zero_n_reg <= ~clear_req;
      end
   end

   // Frame sequencer; select stays low over every bit of the word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ODC_H_IDLE;
         cnt_reg <= 8'h00;
         bits_reg <= 6'h00;
         tx_reg <= '0;
         rx_reg <= '0;
         sel_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         sdi_reg <= 1'b0;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         cnt_reg <= half_end ? 8'h00 : cnt_reg + 8'h01;
         case (state_reg)
            ODC_H_IDLE: begin
               cnt_reg <= 8'h00;
               if (start && !odc_word_legal(tx_word[23:0])) begin
                  refused_reg <= 1'b1;
               end else if (start) begin
                  // Short word is left-aligned so the MSB goes first
                  tx_reg <= long_word ? tx_word :
                            {tx_word[23:0], ODC_PAD_BITS'(0)};
                  sdi_reg <= long_word ? tx_word[31] : tx_word[23];
                  bits_reg <= long_word ? 6'(ODC_WORD_LONG) :
                              6'(ODC_WORD_SHORT);
                  sel_n_reg <= 1'b0;
                  state_reg <= ODC_H_LOW;
               end
            end
            ODC_H_LOW: begin
               if (half_end) begin
                  sck_reg <= 1'b1;
                  state_reg <= ODC_H_HIGH;
               end
            end
            ODC_H_HIGH: begin
               if (half_end) begin
                  // Take the chained bit just before the fall; device output
                  // plus our two stages lag the last fall by five clocks,
                  // too long to fit inside one low phase
                  rx_reg <= {rx_reg[ODC_WORD_LONG-2:0], sdo_s2_reg};
                  sck_reg <= 1'b0;
                  tx_reg <= {tx_reg[ODC_WORD_LONG-2:0], 1'b0};
                  sdi_reg <= tx_reg[ODC_WORD_LONG-2];
                  bits_reg <= bits_reg - 6'h01;
                  state_reg <= (bits_reg == 6'h01) ? ODC_H_TAIL : ODC_H_LOW;
               end
            end
            ODC_H_TAIL: begin
               // Hold select low a half period past the last edge
               if (half_end) begin
                  sel_n_reg <= 1'b1;
                  state_reg <= ODC_H_GAP;
               end
            end
            ODC_H_GAP: begin
               if (half_end) begin
                  done_reg <= 1'b1;
                  state_reg <= ODC_H_IDLE;
               end
            end
            default: begin
               state_reg <= ODC_H_IDLE;
            end
         endcase
      end
   end

   assign link.select_load_n = sel_n_reg;
   assign link.sck = sck_reg;
   assign link.sdi = sdi_reg;
   assign link.async_zero_n = zero_n_reg;
   assign busy = (state_reg != ODC_H_IDLE);
   assign done = done_reg;
   assign refused = refused_reg;
   assign rx_word = rx_reg;

endmodule : odc_host_end

// ===== verif/odc_link_sva.sv
// Link checker: watches the serial pins between host and device ends.
// Assumes four clk cycles per serial clock half and a 16-bit data field.
`timescale 1ns/10ps
module odc_link_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic select_load_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic async_zero_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [31:0] hist_reg;
   logic [5:0] rise_cnt_reg;

   // Bits the device took; starts at zero like its shift register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hist_reg <= 32'h0;
      end else if ($rose(sck) && !select_load_n) begin
         hist_reg <= {hist_reg[30:0], sdi};
      end
   end

   // Rising serial edges in the current frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_cnt_reg <= 6'h0;
      end else if ($fell(select_load_n)) begin
         rise_cnt_reg <= 6'h0;
      end else if ($rose(sck) && !select_load_n) begin
         rise_cnt_reg <= rise_cnt_reg + 6'h1;
      end
   end

   sequence sck_high_phase;
      sck [*4] ##1 !sck;
   endsequence
   sequence frame_lead;
      !sck [*4] ##1 sck;
   endsequence
   sequence frame_span;
      ##[190:270] $rose(select_load_n);
   endsequence

   AST_SCK_IDLE: assert property (select_load_n |-> !sck)
      else $error("serial clock moved while select high");
   AST_SEL_LEAD: assert property ($fell(select_load_n) |-> frame_lead)
      else $error("first serial rise not four cycles after select");
   AST_SCK_HALF: assert property ($rose(sck) |-> sck_high_phase)
      else $error("serial clock high phase wrong");
   AST_SDI_HOLD: assert property ($rose(sck) |-> $stable(sdi) [*4])
      else $error("data changed around serial rise");
   AST_FRAME_BITS: assert property ($rose(select_load_n) |->
      (rise_cnt_reg == 6'h18 || rise_cnt_reg == 6'h20))
      else $error("frame length not 24 or 32 bits");
   AST_FRAME_LEN: assert property ($fell(select_load_n) |-> frame_span)
      else $error("frame did not end in time");
   AST_SDO_DELAY: assert property ($rose(sck) |-> sdo == hist_reg[31])
      else $error("serial out not input delayed 32 rises");
   AST_SDO_QUIET: assert property (select_load_n [*4] |-> $stable(sdo))
      else $error("serial out moved while deselected");
endmodule : odc_link_sva

// ===== verif/octal_dac_serial_control_tb_top.sv
// Bench: host end drives device end over the link, expected codes here.
// Assumes 10 MHz clk and the default 16-bit code and serial divider.
`timescale 1ns/10ps
module octal_dac_serial_control_tb_top;
   import odc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [31:0] tx_word = 32'h0;
   logic long_word = 1'b0;
   logic clear_req = 1'b0;
   logic busy, done, refused, exec_pulse;
   logic [31:0] rx_word;
   logic [127:0] dac_code_flat;
   logic [7:0] powered_down;
   logic [3:0] last_cmd;
   logic [15:0] in_m [8];
   logic [15:0] dac_m [8];
   logic [7:0] pd_m = 8'h00;
   int failures = 0;
   int checks = 0;
   int execs = 0;

   odc_link_if odc_link_if_inst ();
   odc_host_end odc_host_end_inst (.clk(clk), .rst(rst),
      .link(odc_link_if_inst.host), .start(start), .tx_word(tx_word),
      .long_word(long_word), .clear_req(clear_req), .busy(busy),
      .done(done), .refused(refused), .rx_word(rx_word));
   odc_dac_end odc_dac_end_inst (.clk(clk), .rst(rst),
      .link(odc_link_if_inst.device), .dac_code_flat(dac_code_flat),
      .powered_down(powered_down), .exec_pulse(exec_pulse),
      .last_cmd(last_cmd));
   odc_link_sva odc_link_sva_inst (.clk(clk), .rst(rst),
      .select_load_n(odc_link_if_inst.select_load_n),
      .sck(odc_link_if_inst.sck), .sdi(odc_link_if_inst.sdi),
      .sdo(odc_link_if_inst.sdo),
      .async_zero_n(odc_link_if_inst.async_zero_n));

   // Clock and executed-command counter
   always #50 clk = ~clk;
   always @(posedge clk) if (exec_pulse === 1'b1) execs++;

   task automatic finish_test;
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Expected registers; own decode, kept apart from the design's
   task automatic model(input logic [23:0] w);
      logic [3:0] c;
      logic [7:0] m;
      c = w[23:20];
      m = (w[19:16] == 4'hf) ? 8'hff : 8'h01 << w[18:16];
      for (int i = 0; i < 8; i++) begin
         if (m[i] && c != 4'h1 && c < 4'h4) in_m[i] = w[15:0];
         if ((m[i] && (c == 4'h1 || c == 4'h3)) || c == 4'h2) begin
            dac_m[i] = in_m[i];
            pd_m[i] = 1'b0;
         end
         if (m[i] && c == 4'h4) pd_m[i] = 1'b1;
      end
   endtask : model

   task automatic check_all;
      for (int i = 0; i < 8; i++) begin
         cmp(dac_code_flat[16*i +: 16], dac_m[i]);
      end
      cmp(powered_down, pd_m);
   endtask : check_all

   // One whole frame; waits for done, then for the command to land
   task automatic send(input logic [31:0] w, input logic lw);
      int n;
      logic got;
      n = execs;
      got = 1'b0;
      @(posedge clk);
      start <= 1'b1;
      tx_word <= w;
      long_word <= lw;
      @(posedge clk);
      start <= 1'b0;
      #1;
      cmp(busy, 1'b1);
      for (int k = 0; k < 400 && !got; k++) begin
         @(posedge clk);
         #1;
         got = (done === 1'b1);
      end
      repeat (8) @(posedge clk);
      model(w[23:0]);
      cmp(got, 1'b1);
      cmp(busy, 1'b0);
      cmp(execs, n + 1);
      cmp(last_cmd, w[23:20]);
      check_all();
   endtask : send

   task automatic t_reset;
      check_all();
      cmp(last_cmd, 4'hf);
      cmp(odc_link_if_inst.sdo, 1'b0);
   endtask : t_reset

   task automatic t_write_update;
      send(32'h00031234, 1'b0);
      send(32'h00130000, 1'b0);
   endtask : t_write_update

   task automatic t_channels;
      for (int i = 0; i < 8; i++)
         send({8'h00, 4'h3, 4'(i), 4'(i), 12'h5a3}, 1'b0);
   endtask : t_channels

   task automatic t_power;
      send(32'h004f0000, 1'b0);
      send(32'h00049999, 1'b0);
      send(32'h00120000, 1'b0);
   endtask : t_power

   task automatic t_long_nop;
      send(32'ha5260abc, 1'b1);
      send(32'hfffff123, 1'b1);
   endtask : t_long_nop

   // Reserved command and address: refused, nothing reaches the pins
   task automatic t_refuse(input logic [31:0] w);
      int n;
      logic seen;
      n = execs;
      seen = 1'b0;
      @(posedge clk);
      start <= 1'b1;
      tx_word <= w;
      @(posedge clk);
      start <= 1'b0;
      // Refusal pulse stands only in the cycle after the start edge
      repeat (3) begin
         #1;
         seen = seen | (refused === 1'b1);
         @(posedge clk);
      end
      cmp(seen, 1'b1);
      cmp(odc_link_if_inst.select_load_n, 1'b1);
      repeat (8) @(posedge clk);
      cmp(execs, n);
   endtask : t_refuse

   // Second long frame pushes the first word out of the serial output
   task automatic t_chain;
      send(32'h3c328001, 1'b1);
      send(32'h00ff0000, 1'b1);
      cmp(rx_word, 32'h3c328001);
   endtask : t_chain

   // Clear zeroes codes but keeps power-down flags
   task automatic t_clear;
      send(32'h00470000, 1'b0);
      @(posedge clk);
      clear_req <= 1'b1;
      repeat (3) @(posedge clk);
      clear_req <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         in_m[i] = 16'h0;
         dac_m[i] = 16'h0;
      end
      check_all();
      send(32'h001f0000, 1'b0);
   endtask : t_clear

   // Watchdog: whole run is under 1 ms of frames
   initial begin
      #3000000;
      failures++;
      finish_test();
   end

   initial begin
      for (int i = 0; i < 8; i++) begin
         in_m[i] = 16'h0;
         dac_m[i] = 16'h0;
      end
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_write_update();
      t_channels();
      t_power();
      t_long_nop();
      t_refuse(32'h00521234);
      t_refuse(32'h00081234);
      t_chain();
      t_clear();
      finish_test();
   end
endmodule : octal_dac_serial_control_tb_top
